// *** rtl/fcpb_cfg.svh ***
/*
  timing counts and field constants for the fifo port bus host controller.
  assumes a 40 MHz clock; every phase is a whole number of clock cycles.
*/
`ifndef FCPB_CFG_SVH
`define FCPB_CFG_SVH
// ----------------------------------------
// timing
// ----------------------------------------
`define FCPB_CLK_PERIOD_NS 25
`define FCPB_PHASE_NS 75
`define FCPB_PHASE_CYC ((`FCPB_PHASE_NS + `FCPB_CLK_PERIOD_NS - 1) / `FCPB_CLK_PERIOD_NS)
// ----------------------------------------
// command fields
// ----------------------------------------
`define FCPB_ADDR_W 4
`define FCPB_DATA_W 8
`define FCPB_IDLE_BYTE 8'h00
`endif

// *** rtl/fcpb_pkg.sv ***
/*
  types for the fifo port bus host controller.
  assumes the cfg header is included by users that need numbers.
*/
package fcpb_pkg;
  // bus signal set in use
  typedef enum logic {FCPB_MUX, FCPB_GEN} fcpb_mode_t;
  // kind of access the user asks for
  typedef enum logic [1:0] {FCPB_REG, FCPB_DMA, FCPB_ACK} fcpb_kind_t;
endpackage

// *** rtl/fcpb_host.sv ***
/*
  host controller that drives one cpu port of a byte fifo device, either
  over the multiplexed address/data bus or the generalized strobe bus.
  assumes device pins are synchronous to clock; the bench resolves the
  shared data wire and the open-drain pins from the enables.
*/
// Contract
// RL1 - muxed mode shares address and data wires
// RL2 - device latches chip select at strobe rise
// RL3 - address, select, ack valid while strobe low
// RL4 - read/write high reads, low writes
// RL5 - four address bits pick sixteen registers
// RL6 - data strobe times the byte transfer
// RL7 - dma strobe moves byte without address
// RL8 - request/wait is dma request or wait
// RL9 - generalized mode uses separate read, write
// RL10 - device answers only with chip enable; the model also answers dma cycles with chip_sel_n high
// RL11 - control/data high control, low data
// RL12 - dma controller asserts dma acknowledge
// RL13 - host acknowledges interrupt via ack line
// RL14 - device passes chain enable downstream
// RL15 - device takes chain enable from upstream
// RL16 - device requests interrupt open-drain low
// RL17 - chain out low while pending or in
// RL18 - device drives data only on reads
`timescale 1ns/1ps
`include "fcpb_cfg.svh"
module fcpb_host #(
  parameter int unsigned PHASE_CYC = `FCPB_PHASE_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // user command port
  input wire logic cmd_valid,
  input wire fcpb_pkg::fcpb_mode_t cmd_mode,
  input wire fcpb_pkg::fcpb_kind_t cmd_kind,
  input wire logic cmd_read,
  input wire logic cmd_ctrl,
  input wire logic [3:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_rdata,
  // shared data wire
  input wire logic [7:0] bus_in,
  output logic [7:0] bus_out,
  output logic bus_oe,
  // multiplexed bus strobes
  output logic address_strobe_n,
  output logic data_strobe_n,
  output logic rw,
  output logic chip_sel_n,
  output logic dma_byte_strobe_n,
  output logic reg_addr_bit0,
  output logic reg_addr_bit1,
  output logic reg_addr_bit2,
  output logic reg_addr_bit3,
  // generalized bus strobes
  output logic rd_n,
  output logic wr_n,
  output logic ctrl_data,
  output logic dma_ack_n,
  output logic irq_ack_n,
  // device status pins
  input wire logic req_wait_n,
  input wire logic irq_n,
  output logic irq_seen
);
  import fcpb_pkg::*;

  // the phase timer is eight bits wide; refuse counts it cannot hold
  if (PHASE_CYC < 1 || PHASE_CYC > 255) begin : g_phase_chk
    $error("phase count out of range");
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_GAP, S_DATA, S_WAIT, S_END} fcpb_st_t;
  fcpb_st_t st_r, st_nxt;
  logic [7:0] cnt_r;
  fcpb_mode_t mode_r;
  fcpb_kind_t kind_r;
  logic rd_r, ctrl_r;
  logic [3:0] addr_r;
  logic [7:0] wdata_r;
  fcpb_mode_t mode_e;
  fcpb_kind_t kind_e;

  // command as the pins see it; on the accepting edge the stored copy is
  // still the previous command, so the incoming fields are used directly
  wire take = (st_r == S_IDLE) && cmd_valid;
  assign mode_e = take ? cmd_mode : mode_r;
  assign kind_e = take ? cmd_kind : kind_r;
  wire rd_e = take ? (cmd_read || cmd_kind == FCPB_ACK) : rd_r;
  wire ctrl_e = take ? cmd_ctrl : ctrl_r;
  wire [3:0] addr_e = take ? cmd_addr : addr_r;
  wire [7:0] wdata_e = take ? cmd_wdata : wdata_r;

  // phase timer expiry and the device's wait stretch
  wire phase_done = (cnt_r == 8'(PHASE_CYC - 1));
  wire stretched = (req_wait_n == 1'b0) && (kind_r != FCPB_DMA); // [RL8]
  wire is_mux = (mode_e == FCPB_MUX);
  wire need_addr = is_mux && (kind_e != FCPB_DMA); // dma skips address [RL7]

  // next state; wait is only honoured at the end of the data phase
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      S_IDLE: if (cmd_valid) st_nxt = S_ADDR;
      S_ADDR: begin
        if (!need_addr || phase_done) st_nxt = need_addr ? S_GAP : S_DATA;
      end
      S_GAP: if (phase_done) st_nxt = S_DATA;
      S_DATA: if (phase_done) st_nxt = S_WAIT;
      S_WAIT: if (!stretched) st_nxt = S_END;
      S_END: st_nxt = S_IDLE;
      default: st_nxt = S_IDLE;
    endcase
  end

  // state and counter; counter restarts on every change of state
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      st_r <= S_IDLE;
      cnt_r <= 8'h00;
    end else begin
      st_r <= st_nxt;
      cnt_r <= (st_nxt != st_r) ? 8'h00 : cnt_r + 8'h01;
    end
  end

  // command capture at acceptance
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      mode_r <= FCPB_MUX;
      kind_r <= FCPB_REG;
      rd_r <= 1'b0;
      ctrl_r <= 1'b0;
      addr_r <= 4'h0;
      wdata_r <= `FCPB_IDLE_BYTE;
    end else if (st_r == S_IDLE && cmd_valid) begin
      mode_r <= cmd_mode;
      kind_r <= cmd_kind;
      rd_r <= cmd_read || (cmd_kind == FCPB_ACK);
      ctrl_r <= cmd_ctrl;
      addr_r <= cmd_addr;
      wdata_r <= cmd_wdata;
    end
  end

  // ----------------------------------------
  // pin decode
  // ----------------------------------------
  // the strobe holds through wait so a stretched access stays open
  wire in_data = (st_r == S_DATA) || (st_r == S_WAIT);
  wire in_cycle = (st_r != S_IDLE) && (st_r != S_END);
  wire as_nxt = !(need_addr && st_nxt == S_ADDR); // [RL3]
  wire in_data_nxt = (st_nxt == S_DATA) || (st_nxt == S_WAIT);
  wire cyc_nxt = (st_nxt != S_IDLE) && (st_nxt != S_END);
  wire ds_nxt = !(is_mux && kind_e != FCPB_DMA && in_data_nxt); // [RL6]
  wire dstb_nxt = !(is_mux && kind_e == FCPB_DMA && in_data_nxt); // [RL7]
  wire rd_nxt = !(!is_mux && rd_e && in_data_nxt); // [RL9]
  wire wr_nxt = !(!is_mux && !rd_e && in_data_nxt); // [RL9]
  wire dma_ack_n_nxt = !(!is_mux && kind_e == FCPB_DMA && cyc_nxt); // [RL12]
  wire iack_nxt = !(kind_e == FCPB_ACK && cyc_nxt); // [RL13]
  // select held across the cycle so the device latches it at strobe rise
  wire cs_nxt = !(kind_e != FCPB_DMA && cyc_nxt); // [RL2] [RL10]
  // address on the shared wire first, then write data [RL1]
  wire drv_addr = need_addr && st_nxt == S_ADDR;
  wire drv_data = !rd_e && in_data_nxt;
  wire [7:0] bus_nxt = drv_addr ? {4'h0, addr_e} : wdata_e;

  // registered pins; strobes and enables held idle while no command is accepted
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      address_strobe_n <= 1'b1;
      data_strobe_n <= 1'b1;
      dma_byte_strobe_n <= 1'b1;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      dma_ack_n <= 1'b1;
      irq_ack_n <= 1'b1;
      chip_sel_n <= 1'b1;
      rw <= 1'b1;
      ctrl_data <= 1'b0;
      bus_oe <= 1'b0;
      bus_out <= `FCPB_IDLE_BYTE;
      {reg_addr_bit3, reg_addr_bit2, reg_addr_bit1, reg_addr_bit0} <= 4'h0;
    end else begin
      address_strobe_n <= as_nxt;
      data_strobe_n <= ds_nxt;
      dma_byte_strobe_n <= dstb_nxt;
      rd_n <= rd_nxt;
      wr_n <= wr_nxt;
      dma_ack_n <= dma_ack_n_nxt;
      irq_ack_n <= iack_nxt;
      chip_sel_n <= cs_nxt;
      rw <= rd_e; // high reads, low writes [RL4]
      ctrl_data <= ctrl_e; // [RL11]
      bus_oe <= drv_addr || drv_data; // device owns the wire on reads [RL18]
      bus_out <= bus_nxt;
      {reg_addr_bit3, reg_addr_bit2, reg_addr_bit1, reg_addr_bit0} <= addr_e; // [RL5]
    end
  end

  // ----------------------------------------
  // user side
  // ----------------------------------------
  // read data sampled on the last data cycle, before strobes rise
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      cmd_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= 8'h00;
      irq_seen <= 1'b0;
    end else begin
      cmd_ready <= (st_nxt == S_IDLE) && !(st_r == S_IDLE && cmd_valid);
      rsp_valid <= (st_r == S_WAIT) && !stretched;
      if (st_r == S_WAIT && !stretched && rd_r) begin
        rsp_rdata <= bus_in;
      end
      irq_seen <= !irq_n; // [RL16]
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence addr_phase_s;
    !address_strobe_n && bus_oe;
  endsequence

  as_drives_addr_a: assert property (@(posedge clock) disable iff (!rst_b) // [RL1]
    !address_strobe_n |-> bus_oe && bus_out[3:0] == {reg_addr_bit3, reg_addr_bit2,
    reg_addr_bit1, reg_addr_bit0}) else $error("address not on wire during strobe");
  as_before_ds_a: assert property (@(posedge clock) disable iff (!rst_b) // [RL6]
    addr_phase_s ##1 address_strobe_n |-> data_strobe_n) else $error("strobes overlap");
  as_select_held_a: assert property (@(posedge clock) disable iff (!rst_b) // [RL2]
    $rose(address_strobe_n) |-> !chip_sel_n) else $error("select dropped at strobe rise");
  rw_read_a: assert property (@(posedge clock) disable iff (!rst_b) // [RL4]
    !data_strobe_n && rw |-> !bus_oe) else $error("driving wire during read");
  dma_no_addr_a: assert property (@(posedge clock) disable iff (!rst_b) // [RL7]
    !dma_byte_strobe_n |-> address_strobe_n && chip_sel_n) else $error("dma with address");
  rdwr_excl_a: assert property (@(posedge clock) disable iff (!rst_b) // [RL9]
    !(!rd_n && !wr_n)) else $error("read and write together");
  gen_select_a: assert property (@(posedge clock) disable iff (!rst_b) // [RL10]
    (!rd_n || !wr_n) && dma_ack_n |-> !chip_sel_n) else $error("strobe without enable");
  wait_hold_a: assert property (@(posedge clock) disable iff (!rst_b) // [RL8]
    st_r == S_WAIT && stretched |=> st_r == S_WAIT) else $error("wait not honoured");
  ack_rd_a: assert property (@(posedge clock) disable iff (!rst_b) // [RL13]
    !irq_ack_n && !data_strobe_n |-> rw) else $error("ack cycle not a read");
  as_mux_only_a: assert property (@(posedge clock) disable iff (!rst_b) // [RL9]
    !address_strobe_n |-> mode_r == FCPB_MUX && kind_r != FCPB_DMA)
    else $error("address strobe outside muxed register cycle");
endmodule

// *** sim/fcpb_dev_model.sv ***
/*
  behavioural fifo port device facing the host controller.
  assumes the bench drives hold_n and irq_req; resolves the shared data wire.
*/
`timescale 1ns/1ps
module fcpb_dev_model #(
  parameter logic [7:0] VEC = 8'h005a // arbitrary vector
) (
  // host pins
  input wire logic clock,
  input wire logic [7:0] bus_out,
  input wire logic bus_oe,
  input wire logic address_strobe_n,
  input wire logic data_strobe_n,
  input wire logic rw,
  input wire logic chip_sel_n,
  input wire logic dma_byte_strobe_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic ctrl_data,
  input wire logic dma_ack_n,
  input wire logic irq_ack_n,
  // bench controls and device outputs
  input wire logic hold_n,
  input wire logic irq_req,
  output logic [7:0] bus_in,
  output logic req_wait_n,
  output logic irq_n,
  // interrupt priority chain
  input wire logic irq_chain_in,
  output logic irq_chain_out
);
  logic [7:0] mem [16];
  logic [7:0] gen_r [2];
  logic [7:0] dma_r, last_r, dev_out;
  logic [3:0] addr_r;
  logic cs_r, pend_r = 1'b0, dev_oe, dma_n;
  // drive only on selected, dma or acknowledge reads; a released wire shows the inverse
  assign dma_n = dma_byte_strobe_n & dma_ack_n;
  assign dev_oe = (!data_strobe_n && rw && (!cs_r || !irq_ack_n)) || (!dma_byte_strobe_n && rw)
    || (!rd_n && (!chip_sel_n || !dma_ack_n || !irq_ack_n));
  assign dev_out = !irq_ack_n ? VEC : !dma_n ? dma_r : !rd_n ? gen_r[ctrl_data] : mem[addr_r];
  assign bus_in = bus_oe ? bus_out : dev_oe ? dev_out : ~last_r;
  assign req_wait_n = hold_n;
  assign irq_n = pend_r ? 1'b0 : 1'b1;
  // permission goes down the chain only while nothing waits here
  assign irq_chain_out = irq_chain_in && !pend_r;
  // register file, gen bytes and dma byte
  always_ff @(posedge clock) begin
    last_r <= bus_in;
    if (!address_strobe_n) begin
      addr_r <= bus_in[3:0];
      cs_r <= chip_sel_n;
    end
    if (!data_strobe_n && !rw && !cs_r) mem[addr_r] <= bus_in;
    if (!wr_n && !chip_sel_n && dma_ack_n) gen_r[ctrl_data] <= bus_in;
    if ((!dma_byte_strobe_n && !rw) || (!dma_ack_n && !wr_n)) dma_r <= bus_in;
    if (!irq_ack_n) pend_r <= 1'b0;
    else if (irq_req) pend_r <= 1'b1;
  end
endmodule

// *** sim/tb_fcpb_host.sv ***
/*
  self-checking bench for the fifo port host controller.
  assumes the device model answers at once unless hold_n is low.
*/
`timescale 1ns/1ps
module tb_fcpb_host;
  import fcpb_pkg::*;
  typedef struct {fcpb_mode_t m; fcpb_kind_t k; logic rd, cd; logic [3:0] a; logic [7:0] w, x;} fcpb_row_t;
  logic clock = 0, rst_b = 0, cmd_valid = 0, cmd_read = 0, cmd_ctrl = 0, hold_n = 1, irq_req = 0;
  fcpb_mode_t cmd_mode = FCPB_MUX;
  fcpb_kind_t cmd_kind = FCPB_REG;
  logic [3:0] cmd_addr = 4'h0;
  logic [7:0] cmd_wdata = 8'h00, rsp_rdata, bus_in, bus_out;
  logic cmd_ready, rsp_valid, bus_oe, address_strobe_n, data_strobe_n, rw, chip_sel_n;
  logic dma_byte_strobe_n, reg_addr_bit0, reg_addr_bit1, reg_addr_bit2, reg_addr_bit3;
  logic rd_n, wr_n, ctrl_data, dma_ack_n, irq_ack_n, req_wait_n, irq_n, irq_seen;
  logic irq_chain_in = 1, irq_chain_out;
  int miscompares = 0, checked = 0, rsp_cnt = 0;
  fcpb_row_t rows [12] = '{
    '{FCPB_MUX, FCPB_REG, 0, 0, 4'h0, 8'h0011, 8'h0000}, '{FCPB_MUX, FCPB_REG, 0, 0, 4'hf, 8'h00f0, 8'h0000},
    '{FCPB_MUX, FCPB_REG, 1, 0, 4'h0, 8'h0000, 8'h0011}, '{FCPB_MUX, FCPB_REG, 1, 0, 4'hf, 8'h0000, 8'h00f0},
    '{FCPB_GEN, FCPB_REG, 0, 1, 4'h0, 8'h003c, 8'h0000}, '{FCPB_GEN, FCPB_REG, 0, 0, 4'h0, 8'h00c3, 8'h0000},
    '{FCPB_GEN, FCPB_REG, 1, 1, 4'h0, 8'h0000, 8'h003c}, '{FCPB_GEN, FCPB_REG, 1, 0, 4'h0, 8'h0000, 8'h00c3},
    '{FCPB_MUX, FCPB_DMA, 0, 0, 4'h0, 8'h0077, 8'h0000}, '{FCPB_GEN, FCPB_DMA, 1, 0, 4'h0, 8'h0000, 8'h0077},
    '{FCPB_GEN, FCPB_DMA, 0, 0, 4'h0, 8'h0088, 8'h0000}, '{FCPB_MUX, FCPB_DMA, 1, 0, 4'h0, 8'h0000, 8'h0088}};
  fcpb_host #(.PHASE_CYC(3)) dut (.clock, .rst_b, .cmd_valid, .cmd_mode, .cmd_kind, .cmd_read,
    .cmd_ctrl, .cmd_addr, .cmd_wdata, .cmd_ready, .rsp_valid, .rsp_rdata, .bus_in, .bus_out,
    .bus_oe, .address_strobe_n, .data_strobe_n, .rw, .chip_sel_n, .dma_byte_strobe_n,
    .reg_addr_bit0, .reg_addr_bit1, .reg_addr_bit2, .reg_addr_bit3, .rd_n, .wr_n, .ctrl_data,
    .dma_ack_n, .irq_ack_n, .req_wait_n, .irq_n, .irq_seen);
  fcpb_dev_model dev (.clock, .bus_out, .bus_oe, .address_strobe_n, .data_strobe_n, .rw,
    .chip_sel_n, .dma_byte_strobe_n, .rd_n, .wr_n, .ctrl_data, .dma_ack_n, .irq_ack_n,
    .hold_n, .irq_req, .bus_in, .req_wait_n, .irq_n, .irq_chain_in, .irq_chain_out);
  // ----------------------------------------
  // clock, response count, closing
  // ----------------------------------------
  initial forever #12.5 clock = ~clock;
  always @(posedge clock) if (rsp_valid === 1'b1) rsp_cnt++;
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // one command, waited for under a bound
  task automatic run(input fcpb_row_t r);
    int n;
    n = 0;
    @(posedge clock);
    while (cmd_ready !== 1'b1 && n < 300) begin n++; @(posedge clock); end
    cmd_mode <= r.m;
    cmd_kind <= r.k;
    cmd_read <= r.rd;
    cmd_ctrl <= r.cd;
    cmd_addr <= r.a;
    cmd_wdata <= r.w;
    cmd_valid <= 1'b1;
    @(posedge clock);
    cmd_valid <= 1'b0;
    while (rsp_valid !== 1'b1 && n < 600) begin n++; @(posedge clock); end
    chk("done", 8'h0001, {7'h00, rsp_valid});
    if (r.rd) chk("rdata", r.x, rsp_rdata);
  endtask
  initial begin
    #(25 * 20000);
    miscompares++;
    end_of_test();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    fcpb_row_t r;
    repeat (2) @(posedge clock);
    chk("idle pins", 8'h00fe, {address_strobe_n, data_strobe_n, rd_n, wr_n,
      dma_byte_strobe_n, dma_ack_n, irq_ack_n, bus_oe});
    rst_b <= 1'b1;
    foreach (rows[i]) begin
      run(rows[i]);
      if (rows[i].m == FCPB_MUX && rows[i].k == FCPB_REG)
        chk("addr pins", {4'h0, rows[i].a}, {4'h0, reg_addr_bit3, reg_addr_bit2,
          reg_addr_bit1, reg_addr_bit0});
    end
    // wait line low holds the access open
    hold_n <= 1'b0;
    r = rows[2];
    fork run(r); join_none
    repeat (40) @(posedge clock);
    chk("stalled responses", 8'h0c, 8'(rsp_cnt));
    hold_n <= 1'b1;
    wait fork;
    // interrupt raised, seen, acknowledged, once on each bus
    for (int j = 0; j < 2; j++) begin
      irq_req <= 1'b1;
      @(posedge clock) irq_req <= 1'b0;
      repeat (3) @(posedge clock);
      chk("irq seen", 8'h01, {7'h00, irq_seen});
      chk("chain out pending", 8'h00, {7'h00, irq_chain_out});
      run('{j ? FCPB_MUX : FCPB_GEN, FCPB_ACK, 1, 0, 4'h0, 8'h00, 8'h5a});
      chk("irq released", 8'h01, {7'h00, irq_n});
      chk("chain out passed", 8'h01, {7'h00, irq_chain_out});
    end
    // upstream withholds permission
    irq_chain_in <= 1'b0;
    @(posedge clock);
    chk("chain out blocked", 8'h00, {7'h00, irq_chain_out});
    end_of_test();
  end
endmodule
